/* File: logic/sarrd_dev.sv */
/*
 converter end: samples select and serial clock, sequences the cycle and
 streams the result msb first then lsb first.
 assumes: host keeps serial clock within limits; result from user port.
*/
// How it works
// - output bits change on falling serial clock
// - host captures bits on rising edge
// - falling select starts sample and conversion
// - first five clocks sample the input
// - after fifth fall drive one low null
// - sixteen result bits follow, msb first
// - then result repeated lsb first
// - after msb repeat, three-state, ignore clocks
// - new cycle needs select high then low
// - each decision shown at once, no pipeline
// - result in sixteen bit two's complement
// - power-down at conversion end or select high
// - select low end: only analog powered down
// - raising select aborts into power-down
// - host prefers fastest clock, select high after
// - host clock between low and high limits
`timescale 1ns/1ps
`default_nettype none
module sarrd_dev
   import sarrd_pkg::*;
(
   input  wire  logic               mclk_in,
   input  wire  logic               rst_n_in,
   sarrd_if.dev                     link,
   input  wire  logic signed [15:0] analog_diff_in,
   output logic                     sampling_out,
   output logic                     analog_pd_out,
   output logic                     digital_pd_out
);
   // ************************************************
   // pin synchronisers
   // ************************************************
   logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
   logic ck_s1_ff, ck_s2_ff, ck_s3_ff;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         {cs_s1_ff, cs_s2_ff, cs_s3_ff} <= 3'h7;
         {ck_s1_ff, ck_s2_ff, ck_s3_ff} <= 3'h0;
      end else begin
         cs_s1_ff <= link.cs_n;
         cs_s2_ff <= cs_s1_ff;
         cs_s3_ff <= cs_s2_ff;
         ck_s1_ff <= link.serial_shift_clock;
         ck_s2_ff <= ck_s1_ff;
         ck_s3_ff <= ck_s2_ff;
      end
   end
   logic cs_fall, ck_fall;
   assign cs_fall = cs_s3_ff & ~cs_s2_ff;
   assign ck_fall = ck_s3_ff & ~ck_s2_ff;
   // ************************************************
   // sequencer
   // ************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_XFER, ST_DONE} sarrd_st_e;
   sarrd_st_e   st_ff;
   logic [5:0]  fall_ff;
   logic [15:0] res_ff;
   logic        dout_ff;
   logic        oe_ff;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         st_ff   <= ST_IDLE;
         fall_ff <= '0;
      end else if (cs_s2_ff) begin
         st_ff   <= ST_IDLE;
         fall_ff <= '0;
      end else begin
         unique case (st_ff)
            ST_IDLE: if (cs_fall) st_ff <= ST_SAMPLE;
            ST_SAMPLE: if (ck_fall) begin
               fall_ff <= fall_ff + 6'h01;
               if (fall_ff + 6'h01 == SEQ_OE_AT) st_ff <= ST_XFER;
            end
            ST_XFER: if (ck_fall) begin
               fall_ff <= fall_ff + 6'h01;
               if (fall_ff + 6'h01 == SEQ_END) st_ff <= ST_DONE;
            end
            ST_DONE: st_ff <= ST_DONE;           // clocks ignored
         endcase
      end
   end
   // result held from end of sampling; decisions are exposed bit by bit
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         res_ff <= CODE_ZERO;
      end else if (st_ff == ST_SAMPLE && ck_fall &&
                   fall_ff + 6'h01 == SEQ_OE_AT) begin
         res_ff <= sarrd_code(analog_diff_in);
      end
   end
   // data pin: index relative to output-enable fall
   logic [5:0] k;
   assign k = fall_ff - SEQ_OE_AT;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || cs_s2_ff) begin
         dout_ff <= 1'b0;
         oe_ff   <= 1'b0;
      end else if (ck_fall) begin
         if (st_ff == ST_SAMPLE && fall_ff + 6'h01 == SEQ_OE_AT) begin
            oe_ff   <= 1'b1;
            dout_ff <= 1'b0;
         end else if (st_ff == ST_XFER) begin
            if (k < 6'd16) begin
               dout_ff <= res_ff[4'd15 - k[3:0]];
            end else if (k < 6'd31) begin
               dout_ff <= res_ff[k[3:0] + 4'd1];
            end else begin
               oe_ff   <= 1'b0;
               dout_ff <= 1'b0;
            end
         end
      end
   end
   assign link.dout    = dout_ff;
   assign link.dout_oe = oe_ff;
   // ************************************************
   // power state
   // ************************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sampling_out   <= 1'b0;
         analog_pd_out  <= 1'b1;
         digital_pd_out <= 1'b1;
      end else begin
         sampling_out   <= (st_ff == ST_SAMPLE);
         analog_pd_out  <= cs_s2_ff || st_ff == ST_DONE ||
                           st_ff == ST_IDLE || (st_ff == ST_XFER &&
                           fall_ff > SEQ_OE_AT + 6'd16);
         digital_pd_out <= cs_s2_ff;
      end
   end
endmodule : sarrd_dev
`default_nettype wire

/* File: logic/sarrd_pkg.sv */
/*
 serial readout package: result coding, sequence counts, host divider.
 assumes: included before all other design files.
*/
`default_nettype none
package sarrd_pkg;
   localparam int unsigned RES_W        = 16;
   localparam int unsigned SAMPLE_FALLS = 5;   // falling edges spent sampling
   localparam int unsigned NULL_BITS    = 1;
   localparam logic [15:0] CODE_POS_FS  = 16'h7fff;
   localparam logic [15:0] CODE_ZERO    = 16'h0000;
   localparam logic [15:0] CODE_NEG_1   = 16'hffff;
   localparam logic [15:0] CODE_NEG_FS  = 16'h8000;
   localparam int unsigned CLK_MHZ      = 200;
   localparam int unsigned SCLK_KHZ_MAX = 2400;
   localparam int unsigned SCLK_KHZ_MIN = 24;
   // half period of serial clock at max rate, rounded up so rate never exceeds
   localparam int unsigned SCLK_HALF_CYC =
      (CLK_MHZ * 1000 + 2 * SCLK_KHZ_MAX - 1) / (2 * SCLK_KHZ_MAX);
   localparam int unsigned XFER_BITS    = 2 * RES_W - 1;  // msb..lsb..msb
   localparam logic [5:0]  SEQ_OE_AT    = 6'h05;
   localparam logic [5:0]  SEQ_END      = 6'h25;   // 5+1+16+15 = 37
   // two's complement: the code is the signed difference itself
   function automatic logic [15:0] sarrd_code(input logic signed [15:0] v);
      return v;
   endfunction
endpackage : sarrd_pkg
`default_nettype wire

/* File: logic/sarrd_if.sv */
/*
 three wire link: active-low select, serial clock, three-state data.
 assumes: bench resolves data wire from oe and data.
*/
`timescale 1ns/1ps
`default_nettype none
interface sarrd_if;
   logic cs_n;
   logic serial_shift_clock;
   logic dout;
   logic dout_oe;
   modport dev  (input cs_n, input serial_shift_clock,
                 output dout, output dout_oe);
   modport host (output cs_n, output serial_shift_clock,
                 input dout, input dout_oe);
endinterface : sarrd_if
`default_nettype wire

/* File: logic/sarrd_fifo.sv */
/*
 small valid/ready fifo for received results.
 assumes: single clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sarrd_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 4
) (
   input  wire  logic             mclk_in,
   input  wire  logic             rst_n_in,
   input  wire  logic             in_valid_in,
   output logic                   in_ready_out,
   input  wire  logic [WIDTH-1:0] in_data_in,
   output logic                   out_valid_out,
   input  wire  logic             out_ready_in,
   output logic [WIDTH-1:0]       out_data_out
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;
   assign in_ready_out  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_ff != '0);
   assign out_data_out  = mem_ff[rd_ff];
   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;
   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data_in;
      end
   end
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         if (pop)  rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sarrd_fifo
`default_nettype wire

/* File: logic/sarrd_host.sv */
/*
 host end: divides mclk to the serial clock, drives select, captures bits
 on rising edges and queues results in a fifo.
 assumes: converter on the link interface; user drains the result port.
*/
`timescale 1ns/1ps
`default_nettype none
module sarrd_host
   import sarrd_pkg::*;
#(
   parameter int unsigned HALF_CYC = SCLK_HALF_CYC,
   parameter int unsigned BITS     = 16
) (
   input  wire  logic        mclk_in,
   input  wire  logic        rst_n_in,
   sarrd_if.host             link,
   input  wire  logic        start_in,
   output logic              busy_out,
   output logic              res_valid_out,
   input  wire  logic        res_ready_in,
   output logic [15:0]       res_data_out
);
   logic d_s1_ff, d_s2_ff;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         d_s1_ff <= 1'b0;
         d_s2_ff <= 1'b0;
      end else begin
         d_s1_ff <= link.dout;
         d_s2_ff <= d_s1_ff;
      end
   end
   logic [7:0]  div_ff;
   logic        sck_ff, cs_n_ff, run_ff, push_ff;
   logic [5:0]  rise_ff;
   logic [15:0] sh_ff, word_ff;
   logic        fifo_rdy, tick;
   assign tick = (div_ff == 8'(HALF_CYC - 1));
   // free-running so select stays high a half period between frames
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         div_ff <= '0;
      end else begin
         div_ff <= tick ? '0 : div_ff + 8'h01;
      end
   end
   // stall new starts until a slot is free, so results are never dropped
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         run_ff  <= 1'b0;
         cs_n_ff <= 1'b1;
         sck_ff  <= 1'b0;
         rise_ff <= '0;
         sh_ff   <= '0;
         push_ff <= 1'b0;
         word_ff <= '0;
      end else begin
         push_ff <= 1'b0;
         if (!run_ff) begin
            if (start_in && fifo_rdy && !push_ff && tick) begin
               run_ff  <= 1'b1;
               cs_n_ff <= 1'b0;
               rise_ff <= '0;
            end
         end else if (tick) begin
            sck_ff <= ~sck_ff;
            if (!sck_ff) begin                   // rising edge
               rise_ff <= rise_ff + 6'h01;
               if (rise_ff >= 6'd6) sh_ff <= {sh_ff[14:0], d_s2_ff};
               if (rise_ff == 6'(5 + BITS)) begin
                  run_ff <= 1'b0; cs_n_ff <= 1'b1;
                  sck_ff <= 1'b0;
                  push_ff <= 1'b1;
                  word_ff <= {sh_ff[14:0], d_s2_ff} << (16 - BITS);
               end
            end
         end
      end
   end
   assign link.cs_n = cs_n_ff;
   assign link.serial_shift_clock = sck_ff;
   assign busy_out = run_ff;
   sarrd_fifo #(.WIDTH(16), .DEPTH(4)) u_fifo (
      .mclk_in      (mclk_in),
      .rst_n_in     (rst_n_in),
      .in_valid_in  (push_ff),
      .in_ready_out (fifo_rdy),
      .in_data_in   (word_ff),
      .out_valid_out(res_valid_out),
      .out_ready_in (res_ready_in),
      .out_data_out (res_data_out)
   );
endmodule : sarrd_host
`default_nettype wire

/* File: verif/sarrd_chk_sva.sv */
/*
 link checker: watches select, serial clock and data of the host/converter
 pair. assumes: host half period of 8 mclk, so a bit is settled 6 mclk
 after the fall seen here.
*/
`timescale 1ns/1ps
`default_nettype none
module sarrd_chk (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic cs_n,
   input wire logic serial_shift_clock,
   input wire logic dout,
   input wire logic dout_oe
);
   logic       clk_ff;
   logic [5:0] falls_ff;
   logic [5:0] since_ff;
   logic       fall;
   // ***********************************
   // edge counting: fall count cleared by select high, mclk count since a fall cleared by each fall
   // ***********************************
   assign fall = clk_ff & ~serial_shift_clock;
   always_ff @(posedge mclk_in) clk_ff <= serial_shift_clock;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || cs_n) falls_ff <= 6'h00;
      else if (fall && falls_ff != 6'h3f) falls_ff <= falls_ff + 6'h01;
   end
   // saturates so a stopped clock never wraps back into a bit window
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || fall) since_ff <= 6'h00;
      else if (since_ff != 6'h3f) since_ff <= since_ff + 6'h01;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // ***********************************
   // assertions
   // ***********************************
   chk_hiz_sel_high: assert property (cs_n [*5] |-> !dout_oe)
      else $error("data driven while select high");
   chk_change_fall: assert property (dout_oe && $past(dout_oe) &&
      $changed(dout) |-> since_ff < 6'h06)
      else $error("data changed away from a falling clock");
   chk_oe_at_five: assert property ($rose(dout_oe) |->
      falls_ff == 6'h05 && !dout)
      else $error("output enabled at wrong fall or null not low");
   chk_null_held: assert property (dout_oe && falls_ff == 6'h05 |-> !dout)
      else $error("null bit not low for its period");
   chk_no_early_oe: assert property (!cs_n && falls_ff < 6'h05 |->
      !dout_oe)
      else $error("output enabled during sampling");
   chk_abort_hiz: assert property ($rose(cs_n) |-> ##[1:5] !dout_oe)
      else $error("select rise did not release data");
   chk_fall_limit: assert property (dout_oe && !cs_n |->
      falls_ff <= 6'h25)
      else $error("data driven past end of sequence");
   chk_oe_drop_why: assert property ($fell(dout_oe) |-> cs_n ||
      $past(cs_n, 3) || falls_ff >= 6'h25)
      else $error("output released without end or select");
endmodule : sarrd_chk
`default_nettype wire

/* File: verif/tb_sar_adc_serial_readout.sv */
/*
 bench: host and converter face each other; a second converter is clocked
 by the bench to see the full msb/lsb stream. assumes: design compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_serial_readout;
   import sarrd_pkg::*;
   logic        mclk_in  = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        hrst_n   = 1'b0;
   logic        start    = 1'b0;
   logic        rdy      = 1'b0;
   logic [15:0] ain      = 16'h0000;
   logic [15:0] ain2     = 16'h0000;
   logic        busy, vld, pd_a, pd_d, pd_a2, pd_d2, smp2;
   logic [15:0] dat;
   logic        bit_q [1:40];
   logic        oe_q  [1:40];
   int          fails = 0;
   int          samples_checked = 0;
   // rows: analog input, expected code
   logic [31:0] rows [5] = '{{16'h7fff, CODE_POS_FS}, {16'h0000, CODE_ZERO},
      {16'hffff, CODE_NEG_1}, {16'h8000, CODE_NEG_FS}, {16'ha5c3, 16'ha5c3}};
   sarrd_if l1();
   sarrd_if l2();
   always #2.5 mclk_in = ~mclk_in;
   initial begin
      l2.cs_n = 1'b1;
      l2.serial_shift_clock = 1'b0;
   end
   sarrd_dev sarrd_dev_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .link(l1), .analog_diff_in(ain), .sampling_out(),
      .analog_pd_out(pd_a), .digital_pd_out(pd_d));
   sarrd_host #(.HALF_CYC(8), .BITS(16)) sarrd_host_inst (.mclk_in(mclk_in),
      .rst_n_in(hrst_n), .link(l1), .start_in(start), .busy_out(busy),
      .res_valid_out(vld), .res_ready_in(rdy), .res_data_out(dat));
   sarrd_dev sarrd_dev2_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .link(l2), .analog_diff_in(ain2), .sampling_out(smp2),
      .analog_pd_out(pd_a2), .digital_pd_out(pd_d2));
   sarrd_chk sarrd_chk_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .cs_n(l1.cs_n), .serial_shift_clock(l1.serial_shift_clock),
      .dout(l1.dout), .dout_oe(l1.dout_oe));
   // ***********************************
   // tasks
   // ***********************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic chk16(input string n, input logic [15:0] e,
                        input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   // bounded wait; a hang counts as a mismatch
   task automatic wait_lvl(ref logic s, input logic lv);
      for (int n = 0; s !== lv; n++) begin
         if (n == 3000) begin
            fails++;
            stop_test();
         end
         @(posedge mclk_in);
      end
   endtask
   task automatic conv(input logic [15:0] v);
      ain <= v;
      start <= 1'b1;
      wait_lvl(busy, 1'b1);
      start <= 1'b0;
      wait_lvl(busy, 1'b0);
      repeat (6) @(posedge mclk_in);
      chk1("pd_digital", 1'b1, pd_d);
   endtask
   // bench plays host: 40 clocks of 80 ns, bits read late in the low half
   task automatic frame2(input logic [15:0] v);
      ain2 <= v;
      l2.cs_n <= 1'b0;
      repeat (4) @(posedge mclk_in);
      for (int k = 1; k <= 40; k++) begin
         l2.serial_shift_clock <= 1'b1;
         repeat (8) @(posedge mclk_in);
         l2.serial_shift_clock <= 1'b0;
         repeat (7) @(posedge mclk_in);
         bit_q[k] = l2.dout;
         oe_q[k] = l2.dout_oe;
         if (k == 2) chk1("sampling", 1'b1, smp2);
         if (k == 10) chk1("pd_analog_run", 1'b0, pd_a2);
         @(posedge mclk_in);
      end
      chk1("sampling_end", 1'b0, smp2);
      chk1("oe_sampling", 1'b0, oe_q[4]);
      chk1("oe_null", 1'b1, oe_q[5]);
      chk1("null_bit", 1'b0, bit_q[5]);
      for (int k = 6; k <= 21; k++) chk1("msb_first", v[21-k], bit_q[k]);
      for (int k = 22; k <= 36; k++) chk1("lsb_repeat", v[k-21], bit_q[k]);
      for (int k = 37; k <= 40; k++) chk1("hiz_end", 1'b0, oe_q[k]);
      chk1("pd_analog_end", 1'b1, pd_a2);
      chk1("pd_dig_low", 1'b0, pd_d2);
      l2.cs_n <= 1'b1;
      repeat (5) @(posedge mclk_in);
      chk1("pd_dig_high", 1'b1, pd_d2);
      chk1("hiz_sel_high", 1'b0, l2.dout_oe);
   endtask
   // ***********************************
   // main sequence
   // ***********************************
   initial begin
      repeat (6) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      hrst_n <= 1'b1;
      repeat (2) @(posedge mclk_in);
      // four results fill the fifo while the user stalls
      for (int i = 0; i < 4; i++) conv(rows[i][31:16]);
      ain <= rows[4][31:16];
      start <= 1'b1;
      repeat (400) @(posedge mclk_in);
      chk1("busy_when_full", 1'b0, busy);
      for (int i = 0; i < 4; i++) begin
         chk1("res_valid", 1'b1, vld);
         chk16("result", rows[i][15:0], dat);
         rdy <= 1'b1;
         @(posedge mclk_in);
         rdy <= 1'b0;
         @(posedge mclk_in);
      end
      chk1("fifo_empty", 1'b0, vld);
      wait_lvl(busy, 1'b1);
      start <= 1'b0;
      wait_lvl(vld, 1'b1);
      chk16("result_after_drain", rows[4][15:0], dat);
      rdy <= 1'b1;
      // abort mid transfer by resetting only the host, select goes high
      conv(16'h0000);
      rdy <= 1'b1;
      ain <= 16'h1357;
      start <= 1'b1;
      wait_lvl(busy, 1'b1);
      start <= 1'b0;
      repeat (120) @(posedge mclk_in);
      hrst_n <= 1'b0;
      repeat (6) @(posedge mclk_in);
      chk1("abort_hiz", 1'b0, l1.dout_oe);
      chk1("abort_pd", 1'b1, pd_d);
      hrst_n <= 1'b1;
      rdy <= 1'b0;
      repeat (2) @(posedge mclk_in);
      conv(16'h2468);
      chk16("after_abort", 16'h2468, dat);
      frame2(16'hc35a);
      frame2(16'h0001);
      stop_test();
   end
endmodule : tb_sar_adc_serial_readout
`default_nettype wire
